// *** hdl/hrp_read_port.v ***
// Purpose: read side of the asynchronous 16-bit host bus
// Assumes: strobes, address and fifo select arrive unsynchronised
// Notes: sampling adds latency; data follows the strobes by cycles
`include "hrp_regs.vh"

module hrp_read_port #(
  parameter BURST_MAX = `HRP_BURST_MAX,
  parameter RXD_W = 32
) (
  input wire CLK,
  input wire RESETN,
  input wire CHIP_SELECT_N,
  input wire READ_STROBE_N,
  input wire [7:1] ADDR,
  input wire FIFO_SEL,
  output wire [15:0] DATA_O,
  output wire DATA_OE,
  input wire RXD_VALID,
  input wire [RXD_W-1:0] RXD_DATA,
  output wire RXD_READY,
  input wire [31:0] RXS_DATA,
  output wire RXS_POP,
  input wire [31:0] TXS_DATA,
  output wire TXS_POP,
  output wire [7:1] CSR_ADDR,
  output wire CSR_RD,
  input wire [15:0] CSR_RDATA,
  output wire CTR_SNAP
);

  // ----------------------------------------------------------------
  // state codes and target selects
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CSR = 3'b010;
  localparam [2:0] ST_DRIVE = 3'b100;

  localparam [4:0] SEL_RXD = 5'b00001;
  localparam [4:0] SEL_RXS = 5'b00010;
  localparam [4:0] SEL_TXS = 5'b00100;
  localparam [4:0] SEL_CSR = 5'b01000;
  localparam [4:0] SEL_NONE = 5'b10000;

  // cut on purpose: the count register is only HRP_BURST_W bits wide
  localparam [`HRP_BURST_W-1:0] BURST_LIM = BURST_MAX[`HRP_BURST_W-1:0];

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wire [9:0] pins_s;
  wire cs_n_s;
  wire rd_n_s;
  wire fsel_s;
  wire [7:1] addr_s;
  wire active;
  wire [7:0] key_s;
  wire stable;
  wire new_acc;
  wire burst_full;
  wire [4:0] sel;
  wire half_hi;
  wire buf_valid;
  wire [RXD_W-1:0] buf_data;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] key_prev_ff;
  reg [7:0] key_done_ff;
  reg served_ff;
  reg active_ff;
  reg [`HRP_BURST_W-1:0] burst_ff;
  reg [15:0] data_ff;
  reg [15:0] nxt_data;
  reg oe_ff;
  reg snap_ff;
  reg csr_rd_ff;
  reg [7:1] csr_addr_ff;
  reg [7:1] nxt_csr_addr;
  reg rxd_pop_ff;
  reg rxs_pop_ff;
  reg txs_pop_ff;
  reg nxt_rxd_pop;
  reg nxt_rxs_pop;
  reg nxt_txs_pop;
  reg nxt_csr_rd;

  // ----------------------------------------------------------------
  // target decode
  // ----------------------------------------------------------------
  // picks the resource for one access from select and word address
  function [4:0] decode;
    input direct;
    input [7:1] a;
    reg [7:0] win;
    begin
      win = {a[7:3], 3'b000};
      decode = SEL_CSR;
      if (direct) begin
        decode = a[`HRP_SUB_BIT] ? SEL_NONE : SEL_RXD;
      end else if (win == `HRP_RXD_OFF) begin
        decode = a[`HRP_SUB_BIT] ? SEL_NONE : SEL_RXD;
      end else if (win == `HRP_RXS_OFF) begin
        decode = a[`HRP_SUB_BIT] ? SEL_NONE : SEL_RXS;
      end else if (win == `HRP_TXS_OFF) begin
        decode = a[`HRP_SUB_BIT] ? SEL_NONE : SEL_TXS;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // select sampled with address
  hrp_sync #(
    .W(10),
    .RST(`HRP_PIN_RST)
  ) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .din({CHIP_SELECT_N, READ_STROBE_N, FIFO_SEL, ADDR}),
    .dout(pins_s)
  );

  assign cs_n_s = pins_s[9];
  assign rd_n_s = pins_s[8];
  assign fsel_s = pins_s[7];
  assign addr_s = pins_s[6:0];
  assign key_s = {fsel_s, addr_s};

  assign active = ~cs_n_s & ~rd_n_s;

  // ----------------------------------------------------------------
  // receive data buffer
  // ----------------------------------------------------------------
  // a stall by the port holds words here; the source sees ready low
  hrp_buf2 #(
    .W(RXD_W)
  ) u_buf (
    .clk(CLK),
    .resetn(RESETN),
    .in_valid(RXD_VALID),
    .in_data(RXD_DATA),
    .in_ready(RXD_READY),
    .out_valid(buf_valid),
    .out_ready(rxd_pop_ff),
    .out_data(buf_data)
  );

  // ----------------------------------------------------------------
  // access detection
  // ----------------------------------------------------------------
  // an address must read the same twice before it counts, so a skewed
  // multi-bit change on the pins never opens a bogus access
  assign stable = (key_s == key_prev_ff);

  assign new_acc = active & stable & (~served_ff | (key_s != key_done_ff));

  assign burst_full = ~fsel_s & (burst_ff == BURST_LIM);

  assign sel = decode(fsel_s, addr_s);
  assign half_hi = addr_s[`HRP_HALF_BIT];

  // history of the sampled pins and the cycle framing
  always @(posedge CLK) begin
    if (!RESETN) begin
      key_prev_ff <= 8'h00;
      key_done_ff <= 8'h00;
      served_ff <= 1'b0;
      active_ff <= 1'b0;
      burst_ff <= {`HRP_BURST_W{1'b0}};
    end else begin
      key_prev_ff <= key_s;
      active_ff <= active;
      if (!active) begin
        served_ff <= 1'b0;
        burst_ff <= {`HRP_BURST_W{1'b0}};
      end else if (new_acc && !burst_full) begin
        served_ff <= 1'b1;
        key_done_ff <= key_s;
        burst_ff <= burst_ff + {{(`HRP_BURST_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // read sequencer
  // ----------------------------------------------------------------
  // one cycle type serves all
  always @* begin
    nxt_state = state_ff;
    nxt_data = data_ff;
    nxt_csr_addr = csr_addr_ff;
    nxt_csr_rd = 1'b0;
    nxt_rxd_pop = 1'b0;
    nxt_rxs_pop = 1'b0;
    nxt_txs_pop = 1'b0;
    case (state_ff)
      ST_IDLE, ST_DRIVE: begin
        if (!active) begin
          nxt_state = ST_IDLE;
        end else if (new_acc && !burst_full) begin
          nxt_state = ST_DRIVE;
          case (sel)
            SEL_RXD: begin
              if (buf_valid) begin
                nxt_data = half_hi ? buf_data[31:16] : buf_data[15:0];
                nxt_rxd_pop = half_hi;
              end else begin
                // an empty fifo reads as zero and does not move
                nxt_data = `HRP_DATA_RST;
              end
            end
            SEL_RXS: begin
              nxt_data = half_hi ? RXS_DATA[31:16] : RXS_DATA[15:0];
              nxt_rxs_pop = half_hi;
            end
            SEL_TXS: begin
              nxt_data = half_hi ? TXS_DATA[31:16] : TXS_DATA[15:0];
              nxt_txs_pop = half_hi;
            end
            SEL_CSR: begin
              nxt_state = ST_CSR;
              nxt_csr_addr = addr_s;
              nxt_csr_rd = 1'b1;
            end
            default: begin
              nxt_data = `HRP_DATA_RST;
            end
          endcase
        end
      end
      ST_CSR: begin
        // register data are taken in the same cycle as the strobe
        nxt_data = CSR_RDATA;
        nxt_state = active ? ST_DRIVE : ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // registered state and strobes toward the rest of the chip
  always @(posedge CLK) begin
    if (!RESETN) begin
      state_ff <= ST_IDLE;
      data_ff <= `HRP_DATA_RST;
      csr_addr_ff <= 7'h00;
      csr_rd_ff <= 1'b0;
      rxd_pop_ff <= 1'b0;
      rxs_pop_ff <= 1'b0;
      txs_pop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      data_ff <= nxt_data;
      csr_addr_ff <= nxt_csr_addr;
      csr_rd_ff <= nxt_csr_rd;
      rxd_pop_ff <= nxt_rxd_pop;
      rxs_pop_ff <= nxt_rxs_pop;
      txs_pop_ff <= nxt_txs_pop;
    end
  end

  // ----------------------------------------------------------------
  // counter snapshot and bus enable
  // ----------------------------------------------------------------
  // snapshot at cycle start
  always @(posedge CLK) begin
    if (!RESETN) begin
      snap_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      snap_ff <= active & ~active_ff;
      oe_ff <= active;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  // sixteen-bit data path
  assign DATA_O = data_ff;
  assign DATA_OE = oe_ff;
  assign CSR_ADDR = csr_addr_ff;
  assign CSR_RD = csr_rd_ff;
  assign RXS_POP = rxs_pop_ff;
  assign TXS_POP = txs_pop_ff;
  assign CTR_SNAP = snap_ff;

endmodule

// *** hdl/hrp_regs.vh ***
// Purpose: shared constants of the host read port
// Assumes: byte addresses on a 16-bit host bus, word pins A[7:1]
// Notes: included by bare name, guarded against double inclusion
`ifndef HRP_REGS_VH
`define HRP_REGS_VH

// ----------------------------------------------------------------
// clock and host timing
// ----------------------------------------------------------------
`define HRP_CLK_NS 10
`define HRP_ACYC_NS 45
// longest normal burst, in 16-bit words
`define HRP_BURST_MAX 16
`define HRP_BURST_W 5

// ----------------------------------------------------------------
// byte offsets of the fifo ports, 8-byte windows
// ----------------------------------------------------------------
`define HRP_RXD_OFF 8'h00
`define HRP_RXS_OFF 8'h40
`define HRP_TXS_OFF 8'h48

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
// address bit that picks the upper half of a 32-bit entry
`define HRP_HALF_BIT 1
// address bit that must be zero inside a fifo window
`define HRP_SUB_BIT 2
`define HRP_DATA_RST 16'h0000
// pin sampler reset: strobes high, fifo select and address low
`define HRP_PIN_RST 10'h300

`endif

// *** hdl/hrp_sync.v ***
// Purpose: two-flop sampler for pins from outside the clock domain
// Assumes: each bit is sampled on its own, no bus coherence
// Notes: stage one feeds stage two only
module hrp_sync #(
  parameter W = 10,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // ----------------------------------------------------------------
  // two stages; the first is never looked at by other logic
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      meta_ff <= RST;
      sync_ff <= RST;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// *** hdl/hrp_buf2.v ***
// Purpose: two-entry buffer between the receive data source and the port
// Assumes: source holds data while valid and not ready
// Notes: ready is a flop so the source never sees a combinational path
module hrp_buf2 #(
  parameter W = 32
) (
  input wire clk,
  input wire resetn,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] ent0_ff;
  reg [W-1:0] ent1_ff;
  reg [1:0] cnt_ff;
  reg ready_ff;
  reg [1:0] nxt_cnt;
  wire push;
  wire pop;

  assign push = in_valid & ready_ff;
  assign pop = out_ready & (cnt_ff != 2'h0);

  // ----------------------------------------------------------------
  // occupancy; ready drops when both entries are held
  // ----------------------------------------------------------------
  always @* begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  // entry 0 is always the head; entry 1 shifts down on a pop
  always @(posedge clk) begin
    if (!resetn) begin
      ent0_ff <= {W{1'b0}};
      ent1_ff <= {W{1'b0}};
      cnt_ff <= 2'h0;
      ready_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ready_ff <= (nxt_cnt != 2'h2);
      if (pop) begin
        ent0_ff <= (cnt_ff == 2'h2) ? ent1_ff : in_data;
        if (push && cnt_ff == 2'h2) begin
          ent1_ff <= in_data;
        end
      end else if (push) begin
        if (cnt_ff == 2'h0) begin
          ent0_ff <= in_data;
        end else begin
          ent1_ff <= in_data;
        end
      end
    end
  end

  assign in_ready = ready_ff;
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = ent0_ff;

endmodule

// *** verif/hrp_read_port_props.sv ***
// Purpose: timing checks at the host read port pins
// Assumes: strobes pass two flops before the port acts
// Notes: one clock domain, default clocking and disable
module hrp_read_port_props (
  input wire CLK,
  input wire RESETN,
  input wire CHIP_SELECT_N,
  input wire READ_STROBE_N,
  input wire FIFO_SEL,
  input wire DATA_OE,
  input wire RXD_READY,
  input wire RXS_POP,
  input wire TXS_POP,
  input wire CSR_RD,
  input wire CTR_SNAP
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act1_ff, act2_ff;

  // ------------------------------------------------------------
  // sampled cycle view
  // ------------------------------------------------------------
  // mirror the two-flop sampler so checks align with the port
  always @(posedge CLK) begin
    if (!RESETN) begin
      act1_ff <= 1'b0;
      act2_ff <= 1'b0;
    end else begin
      act1_ff <= !CHIP_SELECT_N && !READ_STROBE_N;
      act2_ff <= act1_ff;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_start;
    $rose(act2_ff);
  endsequence
  sequence s_snap;
    ##[1:3] CTR_SNAP;
  endsequence

  AST_OE_ON: assert property (s_start |=> DATA_OE)
    else $error("data bus not driven in cycle");
  AST_OE_OFF: assert property ($fell(act2_ff) |=> !DATA_OE)
    else $error("data bus driven after cycle end");
  AST_OE_IDLE: assert property
    ((CHIP_SELECT_N || READ_STROBE_N) [*5] |-> !DATA_OE)
    else $error("data bus driven with a strobe high");
  AST_SNAP_START: assert property (s_start |-> s_snap)
    else $error("counters not latched at cycle start");
  AST_SNAP_IN_CYCLE: assert property
    (CTR_SNAP |-> $past(act2_ff) ##1 !CTR_SNAP)
    else $error("latch pulse outside cycle or too long");
  AST_POP_PULSE: assert property
    ((RXS_POP || TXS_POP) |=> !(RXS_POP || TXS_POP))
    else $error("status pop longer than one cycle");
  AST_CSR_NORMAL: assert property
    (CSR_RD |-> !$past(FIFO_SEL, 3))
    else $error("register read in fifo direct mode");
  AST_DIRECT_NO_POP: assert property
    ((RXS_POP || TXS_POP) |-> !$past(FIFO_SEL, 3))
    else $error("status pop in fifo direct mode");
  AST_READY_RESET: assert property
    ($rose(RESETN) |-> !RXD_READY ##1 RXD_READY)
    else $error("buffer ready wrong after reset");
endmodule

// *** verif/hrp_host_model.sv ***
// Purpose: host processor driving the read strobes
// Assumes: called at a rising edge, drives by non-blocking
// Notes: 7 clocks a word keeps address stable long enough
module hrp_host_model (
  input wire clk,
  input wire [15:0] data_o,
  output logic cs_n,
  output logic rd_n,
  output logic [7:1] addr,
  output logic fsel
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = 7'h00;
    fsel = 1'b0;
  end

  task automatic rd(input logic [7:1] a, input logic sel,
                    output logic [15:0] d);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    fsel <= sel;
    repeat (7) @(posedge clk);
    d = data_o;
  endtask

  task automatic done(input logic both);
    cs_n <= 1'b1;
    if (both) begin
      rd_n <= 1'b1;
    end
    addr <= ~addr;
    repeat (4) @(posedge clk);
  endtask

  task automatic settle();
    repeat (18) @(posedge clk);
  endtask
endmodule

// *** verif/hrp_read_port_test.sv ***
// Purpose: self-checking bench of the host read port
// Assumes: sources behind the port modelled here
// Notes: expected words come from index based patterns
module hrp_read_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] wr_ix = 5'h00;
  logic [4:0] rd_ix = 5'h00;
  logic [7:0] rxs_n = 8'h00;
  logic [7:0] txs_n = 8'h00;
  int snaps = 0;
  int errors = 0;
  int cmp_count = 0;
  wire cs_n, rd_n, fsel, data_oe, rxd_ready, rxs_pop, txs_pop;
  wire csr_rd, ctr_snap;
  wire [7:1] addr, csr_addr;
  wire [15:0] data_o;

  function automatic logic [31:0] rxw(input logic [4:0] i);
    return {11'h6A1, i, 11'h3C5, i};
  endfunction

  always #5 clk = ~clk;

  // sources: data queue by index, status heads by count
  always @(posedge clk) begin
    if (wr_ix != rd_ix && rxd_ready) begin
      rd_ix <= rd_ix + 5'h01;
    end
    rxs_n <= rxs_n + {7'h00, rxs_pop};
    txs_n <= txs_n + {7'h00, txs_pop};
    snaps <= snaps + (ctr_snap ? 1 : 0);
  end

  hrp_host_model i_host (
    .clk(clk), .data_o(data_o), .cs_n(cs_n), .rd_n(rd_n),
    .addr(addr), .fsel(fsel)
  );

  hrp_read_port i_dut (
    .CLK(clk), .RESETN(resetn), .CHIP_SELECT_N(cs_n),
    .READ_STROBE_N(rd_n), .ADDR(addr), .FIFO_SEL(fsel),
    .DATA_O(data_o), .DATA_OE(data_oe), .RXD_VALID(wr_ix != rd_ix),
    .RXD_DATA(rxw(rd_ix)), .RXD_READY(rxd_ready),
    .RXS_DATA({8'h51, rxs_n, 8'h52, rxs_n}), .RXS_POP(rxs_pop),
    .TXS_DATA({8'h71, txs_n, 8'h72, txs_n}), .TXS_POP(txs_pop),
    .CSR_ADDR(csr_addr), .CSR_RD(csr_rd),
    .CSR_RDATA({9'h14B, csr_addr}), .CTR_SNAP(ctr_snap)
  );

  task automatic chk_w(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_b(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // both status fifos, low then high, two entries each
  task automatic t_status();
    logic [15:0] d;
    logic [7:1] b;
    for (int f = 0; f < 2; f++) begin
      b = f ? 7'h24 : 7'h20;
      for (int k = 0; k < 2; k++) begin
        i_host.rd(b, 1'b0, d);
        chk_w("status low", {f ? 8'h72 : 8'h52, 8'(k)}, d);
        i_host.rd(b | 7'h01, 1'b0, d);
        chk_w("status high", {f ? 8'h71 : 8'h51, 8'(k)}, d);
      end
      // upper word of a status window is unmapped and reads zero
      i_host.rd(b | 7'h02, 1'b0, d);
      chk_w("status sub word", 16'h0000, d);
      i_host.done(f[0]);
    end
    $display("test status done");
  endtask

  // buffer fills with no reads, then drains to empty
  task automatic t_rxd();
    logic [15:0] d;
    logic [31:0] e;
    wr_ix <= 5'h04;
    repeat (10) @(posedge clk);
    chk_b("ready when full", 1'b0, rxd_ready);
    for (int i = 0; i < 5; i++) begin
      e = (i < 4) ? rxw(5'(i)) : 32'h0;
      i_host.rd(7'h00, 1'b0, d);
      chk_w("rx low", e[15:0], d);
      i_host.rd(7'h01, 1'b0, d);
      chk_w("rx high", e[31:16], d);
    end
    i_host.done(1'b1);
    $display("test rx data done");
  endtask

  // register burst past the sixteen word limit
  task automatic t_limit();
    logic [15:0] d;
    logic [7:1] a;
    int s;
    s = snaps;
    for (int i = 0; i < 18; i++) begin
      a = 7'h08 + 7'(i);
      i_host.rd(a, 1'b0, d);
      chk_w("burst word", {9'h14B, (i < 16) ? a : 7'h17}, d);
    end
    i_host.done(1'b1);
    chk_b("one latch", 1'b1, snaps == s + 1);
    chk_b("bus released", 1'b0, data_oe);
    $display("test burst limit done");
  endtask

  // direct burst of 24 words, upper address bits varying
  task automatic t_direct();
    logic [15:0] d;
    logic [31:0] e;
    wr_ix <= 5'h10;
    for (int i = 0; i < 24; i++) begin
      e = rxw(5'(4 + i / 2));
      i_host.rd({5'(i) ^ 5'h0B, 1'b0, i[0]}, 1'b1, d);
      chk_w("direct word", i[0] ? e[31:16] : e[15:0], d);
    end
    i_host.rd(7'h06, 1'b1, d);
    chk_w("direct sub word", 16'h0000, d);
    i_host.done(1'b0);
    chk_b("direct drained", 1'b1, rd_ix == 5'h10);
    $display("test direct done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_status();
    i_host.settle();
    t_rxd();
    t_limit();
    i_host.settle();
    t_direct();
    report_and_stop();
  end

  // watchdog well past the expected run of about 500 clocks
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule

bind hrp_read_port hrp_read_port_props i_props (
  .CLK(CLK), .RESETN(RESETN), .CHIP_SELECT_N(CHIP_SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .FIFO_SEL(FIFO_SEL),
  .DATA_OE(DATA_OE), .RXD_READY(RXD_READY), .RXS_POP(RXS_POP),
  .TXS_POP(TXS_POP), .CSR_RD(CSR_RD), .CTR_SNAP(CTR_SNAP)
);
